//--- hw/dma_two_chan.sv
`timescale 1ns/10ps
`include "dmac_defs.svh"
module dma_two_chan #(
  parameter int BCLK_DIV = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [15:0] cause_basic_i,
  input wire logic [15:0] cause_ext_i,
  input wire logic bus_grant_i,
  input wire logic cpu_access_done_i,
  output logic bus_hold_o,
  output logic xfer_busy_o,
  output logic xfer_chan_o,
  output logic xfer_word_o,
  output logic [19:0] xfer_src_o,
  output logic [19:0] xfer_dst_o,
  output logic xfer_done_o,
  output logic [1:0] underflow_o
);
  import dmac_pkg::*;

  logic [5:0] ctrl_q [2];
  logic [5:0] sel_q [2];
  logic [19:0] src_q [2];
  logic [19:0] dst_q [2];
  logic [19:0] fwd_q [2];
  logic [15:0] rld_q [2];
  logic [15:0] cnt_q [2];
  logic [7:0] area_q [2];
  logic [2:0] gcfg_q;
  logic [1:0] en_q, pend_q, ev_q, reload_q, raw, sw_trig, clr_sw;
  logic [31:0] s1_q, s2_q, prev_q;
  logic [31:0] rd;
  logic ack_q, chan_q, need_cpu_q, tick_q;
  logic [7:0] div_q;
  logic [4:0] xcnt_q, cost;
  state_t st_q;
  logic acc, wr, in_ch, go0, go1, go, start, grant, xend, w;
  logic [4:0] off;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge for Wishbone select
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction
  // Selected cause line of a channel
  function automatic logic pick(input logic [31:0] v, input logic [5:0] s);
    pick = s[`SB_EXT] ? v[5'({1'b1, s[3:0]})] : v[5'({1'b0, s[3:0]})];
  endfunction

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  assign acc = cyc_i & stb_i & ~ack_q;
  assign wr = cyc_i & stb_i & we_i & ack_q; // Write lands on the ack edge
  assign in_ch = adr_i[7:6] == `REG_CH;
  assign off = adr_i[4:0];
  assign go0 = en_q[0] & pend_q[0];
  assign go1 = en_q[1] & pend_q[1];
  assign go = (go0 | go1) & ~need_cpu_q;
  assign start = (st_q == S_IDLE) & go;
  assign w = ~go0;
  assign grant = (st_q == S_HOLD) & bus_grant_i & en_q[chan_q];
  assign xend = (st_q == S_XFER) & tick_q & (xcnt_q == cost - 5'h01);

  // Per channel write strobes and request edges
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      sw_trig[c] = wr & in_ch & (adr_i[5] == c[0]) & (off == `OFF_SEL) & sel_i[0]
                   & dat_i[`SB_SW] & ~dat_i[`SB_EXT] & (dat_i[3:0] == `CAUSE_SW);
      clr_sw[c] = wr & in_ch & (adr_i[5] == c[0]) & (off == `OFF_CTRL) & sel_i[0]
                  & ~dat_i[`CB_PEND];
      raw[c] = sw_trig[c] | (pick(s2_q, sel_q[c]) & ~pick(prev_q, sel_q[c])
               & (sel_q[c][`SB_EXT] | (sel_q[c][3:0] != `CAUSE_SW)));
    end
  end

  // Acknowledge one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else ack_q <= acc;
  end
  assign ack_o = ack_q;

  // Read mux, unmapped reads as zero
  always_comb begin
    rd = 32'h0;
    if (in_ch) begin
      unique case (off)
        `OFF_CTRL: begin
          rd[5:0] = ctrl_q[adr_i[5]];
          rd[`CB_EN] = en_q[adr_i[5]];
          rd[`CB_PEND] = pend_q[adr_i[5]];
        end
        `OFF_SEL: rd[5:0] = sel_q[adr_i[5]];
        `OFF_SRC: rd[19:0] = (ctrl_q[adr_i[5]][`CB_SADV] & en_q[adr_i[5]])
                             ? fwd_q[adr_i[5]] : src_q[adr_i[5]];
        `OFF_DST: rd[19:0] = (ctrl_q[adr_i[5]][`CB_DADV] & en_q[adr_i[5]])
                             ? fwd_q[adr_i[5]] : dst_q[adr_i[5]];
        `OFF_RLD: rd[15:0] = rld_q[adr_i[5]];
        `OFF_CNT: rd[15:0] = cnt_q[adr_i[5]];
        `OFF_AREA: rd[7:0] = area_q[adr_i[5]];
        default: rd = 32'h0;
      endcase
    end else if (adr_i[7:6] == `REG_GLB && adr_i[5:0] == `OFF_GCFG) begin
      rd[2:0] = gcfg_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) dat_o <= 32'h0;
    else if (acc && !we_i) dat_o <= rd;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gcfg_q <= `GCFG_RST;
      for (int c = 0; c < 2; c++) begin
        ctrl_q[c] <= `CTRL_RST;
        sel_q[c] <= `SEL_RST;
        area_q[c] <= `AREA_RST;
        src_q[c] <= `PTR_RST;
        dst_q[c] <= `PTR_RST;
        rld_q[c] <= `CNT_RST;
      end
    end else if (wr) begin
      if (adr_i[7:6] == `REG_GLB && adr_i[5:0] == `OFF_GCFG && sel_i[0]) gcfg_q <= dat_i[2:0];
      if (in_ch) begin
        unique case (off)
          `OFF_CTRL: if (sel_i[0]) ctrl_q[adr_i[5]] <= dat_i[5:0];
          `OFF_SEL: if (sel_i[0]) sel_q[adr_i[5]] <= {1'b0, dat_i[4:0]};
          `OFF_AREA: if (sel_i[0]) area_q[adr_i[5]] <= dat_i[7:0];
          `OFF_SRC: if (ctrl_q[adr_i[5]][`CB_SADV] || !en_q[adr_i[5]])
            src_q[adr_i[5]] <= 20'(merge({12'h0, src_q[adr_i[5]]}, dat_i, sel_i));
          `OFF_DST: if (ctrl_q[adr_i[5]][`CB_DADV] || !en_q[adr_i[5]])
            dst_q[adr_i[5]] <= 20'(merge({12'h0, dst_q[adr_i[5]]}, dat_i, sel_i));
          `OFF_RLD: rld_q[adr_i[5]] <= 16'(merge({16'h0, rld_q[adr_i[5]]}, dat_i, sel_i));
          default: ;
        endcase
      end
    end
  end

  // Enable and pending reload marker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 2'b00;
      reload_q <= 2'b00;
    end else begin
      if (start) reload_q[w] <= 1'b0;
      if (xend && cnt_q[chan_q] == `CNT_RST && !ctrl_q[chan_q][`CB_RPT])
        en_q[chan_q] <= 1'b0;
      for (int c = 0; c < 2; c++) begin
        if (wr && in_ch && adr_i[5] == c[0] && off == `OFF_CTRL && sel_i[0]) begin
          en_q[c] <= dat_i[`CB_EN];
          if (dat_i[`CB_EN]) reload_q[c] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  // Two-flop synchroniser on cause lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 32'h0;
      s2_q <= 32'h0;
      prev_q <= 32'h0;
    end else begin
      s1_q <= {cause_ext_i, cause_basic_i};
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  // Bus clock sampling period
  always_ff @(posedge clk_i) begin
    if (rst_i || div_q == 8'(BCLK_DIV - 1)) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) tick_q <= 1'b0;
    else tick_q <= div_q == 8'(BCLK_DIV - 1);
  end

  // Events held until the next sampling point
  always_ff @(posedge clk_i) begin
    if (rst_i) ev_q <= 2'b00;
    else if (tick_q) ev_q <= 2'b00;
    else ev_q <= ev_q | raw;
  end

  // Pending flags; a sampled set wins over any clear
  always_ff @(posedge clk_i) begin
    if (rst_i) pend_q <= 2'b00;
    else begin
      for (int c = 0; c < 2; c++) begin
        if (tick_q && (ev_q[c] || raw[c])) pend_q[c] <= 1'b1;
        else if (clr_sw[c]) pend_q[c] <= 1'b0;
        else if (grant && chan_q == c[0]) pend_q[c] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      chan_q <= 1'b0;
      xcnt_q <= 5'h00;
    end else begin
      unique case (st_q)
        S_IDLE: if (start) begin
          st_q <= S_HOLD;
          chan_q <= w;
        end
        S_HOLD: if (!en_q[chan_q]) st_q <= S_IDLE;
        else if (bus_grant_i) begin
          st_q <= S_XFER;
          xcnt_q <= 5'h00;
        end
        S_XFER: if (xend) st_q <= S_IDLE;
        else if (tick_q) xcnt_q <= xcnt_q + 5'h01;
      endcase
    end
  end

  // CPU must complete one access between transfers
  always_ff @(posedge clk_i) begin
    if (rst_i) need_cpu_q <= 1'b0;
    else if (xend) need_cpu_q <= 1'b1;
    else if (cpu_access_done_i) need_cpu_q <= 1'b0;
  end

  // Pointer and counter: reload, step, underflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < 2; c++) begin
        fwd_q[c] <= `PTR_RST;
        cnt_q[c] <= `CNT_RST;
      end
    end else if (start && reload_q[w]) begin
      fwd_q[w] <= ctrl_q[w][`CB_SADV] ? src_q[w] : dst_q[w];
      cnt_q[w] <= rld_q[w];
    end else if (xend) begin
      fwd_q[chan_q] <= fwd_q[chan_q]
                       + (ctrl_q[chan_q][`CB_BYTE] ? `UNIT_BYTE : `UNIT_WORD);
      if (cnt_q[chan_q] != `CNT_RST) cnt_q[chan_q] <= cnt_q[chan_q] - 16'h0001;
      else if (ctrl_q[chan_q][`CB_RPT]) cnt_q[chan_q] <= rld_q[chan_q];
    end
  end

  // Cost of the committed transfer
  xfer_cost cost_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .word_i(~ctrl_q[chan_q][`CB_BYTE]),
    .bus8_i(gcfg_q[`GB_BUS8]),
    .exp_i(gcfg_q[`GB_EXP]),
    .sfrw_i(gcfg_q[`GB_SFRW]),
    .src_area_i(area_t'(area_q[chan_q][1:0])),
    .src_wait_i(area_q[chan_q][3:2]),
    .src_odd_i(xfer_src_o[0]),
    .dst_area_i(area_t'(area_q[chan_q][5:4])),
    .dst_wait_i(area_q[chan_q][7:6]),
    .dst_odd_i(xfer_dst_o[0]),
    .cost_o(cost)
  );

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_hold_o <= 1'b0;
      xfer_busy_o <= 1'b0;
      xfer_done_o <= 1'b0;
      underflow_o <= 2'b00;
    end else begin
      bus_hold_o <= (st_q == S_IDLE) ? start : !(xend || (st_q == S_HOLD && !en_q[chan_q]));
      xfer_busy_o <= (st_q == S_XFER) ? !xend : grant;
      xfer_done_o <= xend;
      underflow_o <= {2{xend && cnt_q[chan_q] == `CNT_RST}} & {chan_q, ~chan_q};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_chan_o <= 1'b0;
      xfer_word_o <= 1'b0;
      xfer_src_o <= `PTR_RST;
      xfer_dst_o <= `PTR_RST;
    end else begin
      xfer_chan_o <= chan_q;
      xfer_word_o <= ~ctrl_q[chan_q][`CB_BYTE];
      xfer_src_o <= ctrl_q[chan_q][`CB_SADV] ? fwd_q[chan_q] : src_q[chan_q];
      xfer_dst_o <= ctrl_q[chan_q][`CB_DADV] ? fwd_q[chan_q] : dst_q[chan_q];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  xfer_length_a: assert property (xend |=> st_q == S_IDLE && xcnt_q == $past(cost) - 5'h01)
    else $error("transfer length differs from cost");
  byte_cost_a: assert property (st_q == S_XFER && !xfer_word_o && gcfg_q == `GCFG_RST
    && area_q[chan_q] == `AREA_RST |-> cost == 5'h02)
    else $error("byte cost on internal memory wrong");
  grant_clear_a: assert property (grant && !(tick_q && (ev_q[chan_q] || raw[chan_q]))
    |=> !pend_q[$past(chan_q)])
    else $error("pending not cleared on grant");
  prio_a: assert property (start && go0 |=> chan_q == 1'b0 ##1 st_q != S_IDLE)
    else $error("channel 1 won over channel 0");
  cpu_gap_a: assert property (st_q == S_IDLE && need_cpu_q && !cpu_access_done_i
    |=> st_q == S_IDLE)
    else $error("transfer started without CPU access");
  reload_cnt_a: assert property (start && reload_q[w] |=> cnt_q[$past(w)] == $past(rld_q[w]))
    else $error("counter not reloaded");
  sw_req_a: assert property (sw_trig[0] && !clr_sw[0] |-> ##[1:40] pend_q[0] || st_q != S_IDLE)
    else $error("software trigger lost");
  single_end_a: assert property (xend && cnt_q[chan_q] == `CNT_RST && !ctrl_q[chan_q][`CB_RPT]
    && !wr |=> !en_q[$past(chan_q)])
    else $error("single mode did not stop");
  repeat_a: assert property (xend && cnt_q[chan_q] == `CNT_RST && ctrl_q[chan_q][`CB_RPT]
    |=> cnt_q[$past(chan_q)] == $past(rld_q[chan_q]))
    else $error("repeat mode did not reload");
endmodule // dma_two_chan

//--- inc/dmac_defs.svh
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH
// ----------------------------------------
// Register map, byte offsets
// ----------------------------------------
`define OFF_CTRL 5'h00
`define OFF_SEL 5'h04
`define OFF_SRC 5'h08
`define OFF_DST 5'h0c
`define OFF_RLD 5'h10
`define OFF_CNT 5'h14
`define OFF_AREA 5'h18
`define REG_CH 2'h0
`define REG_GLB 2'h1
`define OFF_GCFG 6'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CB_BYTE 0
`define CB_PEND 1
`define CB_DADV 2
`define CB_EN 3
`define CB_SADV 4
`define CB_RPT 5
`define SB_EXT 4
`define SB_SW 5
`define GB_EXP 0
`define GB_BUS8 1
`define GB_SFRW 2
// ----------------------------------------
// Values and reset values
// ----------------------------------------
`define CAUSE_SW 4'h1
`define PTR_RST 20'h00000
`define CNT_RST 16'h0000
`define CTRL_RST 6'h00
`define SEL_RST 6'h00
`define AREA_RST 8'h00
`define GCFG_RST 3'h0
`define UNIT_BYTE 20'h00001
`define UNIT_WORD 20'h00002
// ----------------------------------------
// Bus cycle counts and coefficients
// ----------------------------------------
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define WAIT_NONE 2'h0
`define WAIT_MAX 2'h3
`define K_INT 3'h1
`define K_INT_W 3'h2
`define K_SFR1 3'h2
`define K_SFR2 3'h3
`define K_SEP0_RD 3'h1
`define K_SEP0_WR 3'h2
`define K_SEP_STEP 3'h1
`define K_MUX12 3'h3
`define K_MUX3 3'h4
`endif

//--- inc/dmac_pkg.sv
package dmac_pkg;
  typedef enum logic [1:0] {AREA_INT, AREA_SFR, AREA_SEP, AREA_MUX} area_t;
  typedef enum logic [1:0] {S_IDLE, S_HOLD, S_XFER} state_t;
endpackage

//--- hw/xfer_cost.sv
`timescale 1ns/10ps
`include "dmac_defs.svh"
module xfer_cost (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic word_i,
  input wire logic bus8_i,
  input wire logic exp_i,
  input wire logic sfrw_i,
  input wire dmac_pkg::area_t src_area_i,
  input wire logic [1:0] src_wait_i,
  input wire logic src_odd_i,
  input wire dmac_pkg::area_t dst_area_i,
  input wire logic [1:0] dst_wait_i,
  input wire logic dst_odd_i,
  output logic [4:0] cost_o
);
  import dmac_pkg::*;
  // ----------------------------------------
  // Bus cycles per access
  // ----------------------------------------
  function automatic logic [1:0] units(input logic word, input logic bus8, input logic exp,
                                       input logic odd);
    if (!word) units = `CYC_ONE;
    else if (bus8 && exp) units = `CYC_TWO;
    else units = odd ? `CYC_TWO : `CYC_ONE;
  endfunction
  // Wait coefficient of one access
  function automatic logic [2:0] coef(input area_t a, input logic [1:0] w, input logic sfrw,
                                      input logic wr);
    unique case (a)
      AREA_INT: coef = (w != `WAIT_NONE) ? `K_INT_W : `K_INT;
      AREA_SFR: coef = sfrw ? `K_SFR2 : `K_SFR1;
      AREA_SEP: begin
        if (w == `WAIT_NONE) coef = wr ? `K_SEP0_WR : `K_SEP0_RD;
        else coef = {1'b0, w} + `K_SEP_STEP;
      end
      AREA_MUX: coef = (w == `WAIT_MAX) ? `K_MUX3 : `K_MUX12;
    endcase
  endfunction
  // Read count times j plus write count times k
  always_ff @(posedge clk_i) begin
    if (rst_i) cost_o <= 5'h00;
    else cost_o <= 5'(units(word_i, bus8_i, exp_i, src_odd_i))
                      * 5'(coef(src_area_i, src_wait_i, sfrw_i, 1'b0))
                 + 5'(units(word_i, bus8_i, exp_i, dst_odd_i))
                      * 5'(coef(dst_area_i, dst_wait_i, sfrw_i, 1'b1));
  end
endmodule // xfer_cost

//--- dv/bus_owner.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bus owner: CPU side of bus arbitration
// ----------------------------------------
module bus_owner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic done_i,
  input wire logic block_i,
  input wire logic slow_i,
  output logic grant_o,
  output logic cpu_done_o
);
  logic [1:0] wait_q;
  logic [1:0] cpu_q;
  // Grant after zero or three cycles, never while blocked
  always_ff @(posedge clk_i) begin
    if (rst_i || !hold_i || block_i) begin
      grant_o <= 1'b0;
      wait_q <= 2'h0;
    end else if (!slow_i || wait_q == 2'h3) begin
      grant_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
  // CPU makes one bus access after every transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_q <= 2'h0;
    end else begin
      cpu_q <= {cpu_q[0], done_i};
    end
  end
  assign cpu_done_o = cpu_q[1];
endmodule // bus_owner

//--- dv/dma_two_chan_tb.sv
`timescale 1ns/10ps
`include "dmac_defs.svh"
module dma_two_chan_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, bus_grant_i, cpu_access_done_i;
  logic bus_hold_o, xfer_busy_o, xfer_chan_o, xfer_word_o, xfer_done_o, block, slow;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [15:0] cause_basic_i, cause_ext_i;
  logic [19:0] xfer_src_o, xfer_dst_o, t_src, t_dst;
  logic [1:0] underflow_o;
  logic t_chan, t_word, t_uf, t_done;
  int error_cnt, tests_run, cpu_cnt, t_cyc;
  // Cost table: gcfg, area, word, odd source, expected cycles
  localparam logic [27:0] COST_TAB [11] = '{28'h0000102, 28'h0001002, 28'h0001103,
    28'h0040003, 28'h0010003, 28'h4010004, 28'h0220003, 28'h0ee0008, 28'h0770006,
    28'h3001004, 28'h3000102};

  dma_two_chan #(.BCLK_DIV(1)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cause_basic_i(cause_basic_i),
    .cause_ext_i(cause_ext_i), .bus_grant_i(bus_grant_i),
    .cpu_access_done_i(cpu_access_done_i), .bus_hold_o(bus_hold_o),
    .xfer_busy_o(xfer_busy_o), .xfer_chan_o(xfer_chan_o), .xfer_word_o(xfer_word_o),
    .xfer_src_o(xfer_src_o), .xfer_dst_o(xfer_dst_o), .xfer_done_o(xfer_done_o),
    .underflow_o(underflow_o));
  bus_owner u_owner (.clk_i(clk_i), .rst_i(rst_i), .hold_i(bus_hold_o),
    .done_i(xfer_done_o), .block_i(block), .slow_i(slow), .grant_o(bus_grant_i),
    .cpu_done_o(cpu_access_done_i));

  // Clock, 40 ns period
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Count CPU accesses between transfers
  always @(posedge clk_i) begin
    if (cpu_access_done_i === 1'b1) cpu_cnt <= cpu_cnt + 1;
  end

  // ----------------------------------------
  // Helpers and scenarios
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] ra(input logic [2:0] c, input logic [4:0] off);
    return {c, off};
  endfunction
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) check("ack", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [2:0] c, input logic [4:0] off, input logic [31:0] d);
    wb(1'b1, ra(c, off), d);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  task automatic trig();
    wr(3'h0, `OFF_SEL, 32'h21);
  endtask
  // Wait for one transfer and capture it
  task automatic xfer(input int lim);
    int n;
    n = 0;
    #1;
    while (xfer_busy_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    t_chan = xfer_chan_o;
    t_word = xfer_word_o;
    t_src = xfer_src_o;
    t_dst = xfer_dst_o;
    t_cyc = 0;
    while (xfer_busy_o === 1'b1 && t_cyc < 300) begin
      @(posedge clk_i);
      #1;
      t_cyc++;
    end
    t_uf = underflow_o[t_chan];
    t_done = xfer_done_o;
  endtask
  task automatic t_reset();
    check("hold", 32'(bus_hold_o), 32'h0);
    rdchk("ctrl0", ra(3'h0, `OFF_CTRL), 32'h0);
    rdchk("cnt1", ra(3'h1, `OFF_CNT), 32'h0);
    wb(1'b1, 8'h60, 32'hffffffff);
    rdchk("unmapped", 8'h60, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_pend();
    wr(3'h1, `OFF_SEL, 32'h2);
    wr(3'h0, `OFF_SEL, 32'h17);
    wr(3'h1, `OFF_CTRL, 32'h0);
    wr(3'h0, `OFF_CTRL, 32'h0);
    cause_basic_i <= 16'h0004;
    cause_ext_i <= 16'h0080;
    repeat (6) @(posedge clk_i);
    rdchk("pend set", ra(3'h1, `OFF_CTRL), 32'h2);
    rdchk("pend ext", ra(3'h0, `OFF_CTRL), 32'h2);
    wr(3'h1, `OFF_CTRL, 32'h2);
    rdchk("pend kept", ra(3'h1, `OFF_CTRL), 32'h2);
    wr(3'h1, `OFF_CTRL, 32'h0);
    rdchk("pend clr", ra(3'h1, `OFF_CTRL), 32'h0);
    cause_basic_i <= 16'h0;
    cause_ext_i <= 16'h0;
    $display("test pending done");
  endtask
  task automatic t_cost();
    logic [27:0] e;
    logic [19:0] s;
    for (int i = 0; i < 11; i++) begin
      e = COST_TAB[i];
      s = {19'h00080, e[8]};
      wb(1'b1, 8'h40, {28'h0, e[27:24]});
      wr(3'h0, `OFF_AREA, {24'h0, e[23:16]});
      wr(3'h0, `OFF_SRC, {12'h0, s});
      wr(3'h0, `OFF_DST, 32'h200);
      wr(3'h0, `OFF_RLD, 32'h0);
      wr(3'h0, `OFF_CTRL, {26'h0, 5'h1c, ~e[12]});
      slow <= i[0];
      trig();
      xfer(100);
      check("cost", t_cyc, {24'h0, e[7:0]});
      check("word", 32'(t_word), 32'(e[12]));
      check("src", 32'(t_src), 32'(s));
      check("repeat uf", 32'(t_uf), 32'h1);
      check("done", 32'(t_done), 32'h1);
    end
    $display("test cost done");
  endtask
  task automatic t_single();
    wb(1'b1, 8'h40, 32'h0);
    wr(3'h0, `OFF_AREA, 32'h0);
    wr(3'h0, `OFF_CTRL, 32'h0);
    wr(3'h0, `OFF_DST, 32'h300);
    wr(3'h0, `OFF_SRC, 32'h10);
    wr(3'h0, `OFF_RLD, 32'h1);
    wr(3'h0, `OFF_CTRL, 32'h0c);
    trig();
    xfer(100);
    check("dst first", 32'(t_dst), 32'h300);
    rdchk("cnt", ra(3'h0, `OFF_CNT), 32'h0);
    trig();
    xfer(100);
    check("dst next", 32'(t_dst), 32'h302);
    check("single uf", 32'(t_uf), 32'h1);
    trig();
    xfer(30);
    check("ended", t_cyc, 32'h0);
    wr(3'h0, `OFF_CTRL, 32'h0e);
    xfer(100);
    check("dst reload", 32'(t_dst), 32'h300);
    $display("test single done");
  endtask
  task automatic t_prio();
    int c0;
    @(posedge clk_i);
    block <= 1'b1;
    wr(3'h0, `OFF_SEL, 32'h2);
    wr(3'h1, `OFF_SEL, 32'h2);
    wr(3'h0, `OFF_CTRL, 32'h2d);
    wr(3'h1, `OFF_CTRL, 32'h2d);
    for (int i = 0; i < 4; i++) begin
      cause_basic_i <= {13'h0, ~i[0], 2'h0};
      repeat (3) @(posedge clk_i);
    end
    rdchk("pend ch0", ra(3'h0, `OFF_CTRL), 32'h2f);
    rdchk("pend ch1", ra(3'h1, `OFF_CTRL), 32'h2f);
    block <= 1'b0;
    xfer(100);
    check("first chan", 32'(t_chan), 32'h0);
    c0 = cpu_cnt;
    xfer(100);
    check("second chan", 32'(t_chan), 32'h1);
    check("cpu gap", cpu_cnt - c0, 32'h1);
    xfer(30);
    check("one per grant", t_cyc, 32'h0);
    rdchk("pend served", ra(3'h1, `OFF_CTRL), 32'h2d);
    $display("test priority done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    cause_basic_i = 16'h0;
    cause_ext_i = 16'h0;
    block = 1'b0;
    slow = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cpu_cnt = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pend();
    t_cost();
    t_single();
    t_prio();
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
endmodule // dma_two_chan_tb
